/* logic/flash_ctrl_pkg.sv */
// Shared constants for the serial flash erase/status command logic
package flash_ctrl_pkg;
   // ----------------------------------------------------------------
   // Opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] WHOLE_ERASE_OP_A = 8'h60;
   localparam logic [7:0] WHOLE_ERASE_OP_B = 8'hc7;
   localparam logic [7:0] STATUS_READ_OP = 8'h05;
   localparam logic [7:0] WRITE_LATCH_SET_OP = 8'h06;
   localparam logic [7:0] WRITE_LATCH_CLEAR_OP = 8'h04;
   localparam logic [7:0] STATUS_WRITE_ARM_OP = 8'h50;
   localparam logic [7:0] STATUS_WRITE_OP = 8'h01;
   localparam int OPCODE_BITS = 8;
   // ----------------------------------------------------------------
   // Status byte layout
   // ----------------------------------------------------------------
   localparam int ST_BUSY = 0;
   localparam int ST_WRITE_LATCH = 1;
   localparam int ST_LEVEL_LO = 2;
   localparam int ST_LEVEL_HI = 4;
   localparam int ST_LOCK = 7;
   localparam int LEVEL_BITS = 3;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int REF_CLK_MHZ = 25;
   localparam int WHOLE_ERASE_TIME_S = 30;
   localparam longint WHOLE_ERASE_CYCLES = longint'(WHOLE_ERASE_TIME_S) * REF_CLK_MHZ * 1000000;
   localparam int STATUS_WRITE_TIME_US = 10;
   localparam int STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_US * REF_CLK_MHZ;
   localparam int SCK_HALF_DIV = 2;
   localparam int SYNC_STAGES = 3;
   typedef enum logic [2:0] {
      CMD_NONE, CMD_ERASE, CMD_LATCH_SET, CMD_LATCH_CLEAR, CMD_ARM, CMD_STATUS_WRITE
   } cmd_kind_t;
endpackage : flash_ctrl_pkg

/* logic/flash_device.sv */
// Device end: serial command logic for erase, write latch and status register
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module flash_device
   import flash_ctrl_pkg::*;
#(
   parameter longint ERASE_CYCLES = WHOLE_ERASE_CYCLES
) (
   input wire logic REF_CLK_IN,
   input wire logic RSTN_IN,
   flash_link_if.device LINK,
   output logic BUSY_OUT,
   output logic ARRAY_ERASED_OUT
);
   // ----------------------------------------------------------------
   // Link domain: shift opcode and data on the serial clock
   // ----------------------------------------------------------------
   logic [7:0] shift_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] opcode_q;
   logic [7:0] data_q;
   logic [7:0] out_q;
   logic [2:0] out_idx_q;
   logic [7:0] status_w;
   logic [7:0] status_link_q;
   logic [7:0] shift_d;
   logic reading_w;
   logic got_op_q;
   logic got_data_q;
   // Link clock only runs inside frames; reset counters asynchronously from select
   // MSB first sampling
   assign shift_d = {shift_q[6:0], LINK.si};
   always_ff @(posedge LINK.sck or posedge LINK.cs_n) begin
      if (LINK.cs_n) begin
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
      end else begin
         shift_q <= shift_d;
         if (bit_cnt_q != 4'hf) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end
      end
   end
   // Opcode and data captured; held stable after select rises for the crossing
   always_ff @(posedge LINK.sck or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         opcode_q <= 8'h00;
         data_q <= 8'h00;
         got_op_q <= 1'b0;
         got_data_q <= 1'b0;
      end else if (!LINK.cs_n) begin
         // Flags drop on the first serial clock of each frame, so a frame cut short after that never replays the last opcode
         if (bit_cnt_q == 4'h0) begin
            got_op_q <= 1'b0;
            got_data_q <= 1'b0;
         end else if (bit_cnt_q == 4'(OPCODE_BITS - 1)) begin
            opcode_q <= shift_d;
            data_q <= 8'h00;
            got_op_q <= 1'b1;
         end else if (bit_cnt_q == 4'(2 * OPCODE_BITS - 1)) begin
            data_q <= shift_d;
            got_data_q <= 1'b1;
         end
      end
   end
   assign reading_w = (opcode_q == STATUS_READ_OP) && (bit_cnt_q >= 4'(OPCODE_BITS));
   always_ff @(negedge LINK.sck or posedge LINK.cs_n) begin
      if (LINK.cs_n) begin
         out_idx_q <= 3'h7;
         out_q <= 8'h00;
      end else if (reading_w) begin
         if (out_idx_q == 3'h7) begin
            out_q <= status_link_q;
         end
         out_idx_q <= out_idx_q - 3'h1;
      end
   end
   // Status snapshot taken in link domain on every serial clock rising edge
   always_ff @(posedge LINK.sck or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         status_link_q <= 8'h00;
      end else begin
         status_link_q <= status_w;
      end
   end
   assign LINK.so = reading_w ? ((out_idx_q == 3'h7) ? status_link_q[7] : out_q[out_idx_q]) : 1'b0;
   assign LINK.so_oe_n = ~reading_w;
   // ----------------------------------------------------------------
   // Crossing into the reference clock domain
   // ----------------------------------------------------------------
   logic cs_n_s;
   logic wp_n_s;
   logic cs_n_prev_q;
   logic cs_rise_w;
   flash_sync3 #(.INIT(1'b1)) u_cs_sync (.clk_in(REF_CLK_IN), .rstn_in(RSTN_IN), .d_in(LINK.cs_n),
      .q_out(cs_n_s));
   flash_sync3 #(.INIT(1'b1)) u_wp_sync (.clk_in(REF_CLK_IN), .rstn_in(RSTN_IN), .d_in(LINK.wp_n),
      .q_out(wp_n_s));
   always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         cs_n_prev_q <= 1'b1;
      end else begin
         cs_n_prev_q <= cs_n_s;
      end
   end
   // Opcode and data are quiet once select is high, so they are safe to read here
   assign cs_rise_w = cs_n_s && !cs_n_prev_q;
   // ----------------------------------------------------------------
   // Command decode and status register
   // ----------------------------------------------------------------
   logic busy_q;
   logic latch_q;
   logic lock_q;
   logic armed_q;
   logic erased_q;
   logic [LEVEL_BITS-1:0] level_q;
   logic [63:0] timer_q;
   logic full_op_w;
   logic full_data_w;
   cmd_kind_t cmd_w;
   logic write_ok_w;
   logic new_lock_w;
   function automatic cmd_kind_t decode(input logic [7:0] op, input logic has_data);
      if (op == WHOLE_ERASE_OP_A || op == WHOLE_ERASE_OP_B) begin
         return CMD_ERASE;
      end else if (op == WRITE_LATCH_SET_OP) begin
         return CMD_LATCH_SET;
      end else if (op == WRITE_LATCH_CLEAR_OP) begin
         return CMD_LATCH_CLEAR;
      end else if (op == STATUS_WRITE_ARM_OP) begin
         return CMD_ARM;
      end else if (op == STATUS_WRITE_OP && has_data) begin
         return CMD_STATUS_WRITE;
      end
      return CMD_NONE;
   endfunction : decode
   // Frame flags are quiet once select is high, like opcode and data
   assign full_op_w = got_op_q;
   assign full_data_w = got_data_q;
   assign cmd_w = full_op_w ? decode(opcode_q, full_data_w) : CMD_NONE;
   // permission from lock and pin before the rise
   assign write_ok_w = wp_n_s || !lock_q;
   assign new_lock_w = wp_n_s ? data_q[ST_LOCK] : (lock_q | data_q[ST_LOCK]);
   assign status_w = {lock_q, 2'b00, level_q, latch_q, busy_q};
   always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         busy_q <= 1'b0;
         latch_q <= 1'b0;
         lock_q <= 1'b0;
         armed_q <= 1'b0;
         erased_q <= 1'b0;
         level_q <= '0;
         timer_q <= 64'h0;
      end else if (busy_q) begin
         // only the timer runs while busy
         if (timer_q == 64'h0) begin
            busy_q <= 1'b0;
            latch_q <= 1'b0;
         end else begin
            timer_q <= timer_q - 64'h1;
         end
      end else if (cs_rise_w) begin
         armed_q <= (cmd_w == CMD_ARM);
         case (cmd_w)
            CMD_LATCH_SET: latch_q <= 1'b1;
            CMD_LATCH_CLEAR: latch_q <= 1'b0;
            // erase gated by latch and protection
            CMD_ERASE: begin
               if (latch_q && level_q == '0) begin
                  busy_q <= 1'b1;
                  erased_q <= 1'b1;
                  timer_q <= 64'(ERASE_CYCLES - 1);
               end
            end
            CMD_STATUS_WRITE: begin
               if ((armed_q || latch_q) && write_ok_w) begin
                  level_q <= data_q[ST_LEVEL_HI:ST_LEVEL_LO];
                  lock_q <= new_lock_w;
                  busy_q <= 1'b1;
                  timer_q <= 64'(STATUS_WRITE_CYCLES - 1);
               end
            end
            default: ;
         endcase
      end
   end
   assign BUSY_OUT = busy_q;
   assign ARRAY_ERASED_OUT = erased_q && !busy_q;
endmodule : flash_device
`default_nettype wire

/* logic/flash_host.sv */
// Host end: issues one command per request over the serial link
`timescale 1ns/1ps
`default_nettype none
module flash_host
   import flash_ctrl_pkg::*;
(
   input wire logic REF_CLK_IN,
   input wire logic RSTN_IN,
   flash_link_if.host LINK,
   input wire logic REQ_IN,
   input wire logic [7:0] OPCODE_IN,
   input wire logic [7:0] DATA_IN,
   input wire logic HAS_DATA_IN,
   input wire logic [3:0] READ_BYTES_IN,
   input wire logic WP_N_IN,
   output logic READY_OUT,
   output logic DONE_OUT,
   output logic [7:0] STATUS_OUT
);
   typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_END} host_state_t;
   host_state_t state_q;
   logic [15:0] tx_q;
   logic [7:0] rx_q;
   logic [7:0] status_q;
   logic [7:0] bits_left_q;
   logic [1:0] div_q;
   logic sck_q;
   logic cs_n_q;
   logic done_q;
   logic so_s;
   logic is_read_q;
   flash_sync3 #(.INIT(1'b0)) u_so_sync (.clk_in(REF_CLK_IN), .rstn_in(RSTN_IN), .d_in(LINK.so),
      .q_out(so_s));
   // ----------------------------------------------------------------
   // Serial clock from divider; one frame per request
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         state_q <= S_IDLE;
         tx_q <= 16'h0;
         rx_q <= 8'h0;
         status_q <= 8'h0;
         bits_left_q <= 8'h00;
         div_q <= 2'h0;
         sck_q <= 1'b0;
         cs_n_q <= 1'b1;
         done_q <= 1'b0;
         is_read_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            S_IDLE: begin
               // select framed around the whole command
               if (REQ_IN) begin
                  cs_n_q <= 1'b0;
                  tx_q <= {OPCODE_IN, DATA_IN};
                  is_read_q <= (OPCODE_IN == STATUS_READ_OP);
                  // Eight bits of count: fifteen status bytes plus the opcode need 128 clocks
                  bits_left_q <= (OPCODE_IN == STATUS_READ_OP) ? 8'(OPCODE_BITS + 8 * READ_BYTES_IN) :
                     (HAS_DATA_IN ? 8'(2 * OPCODE_BITS) : 8'(OPCODE_BITS));
                  div_q <= 2'h0;
                  state_q <= S_SHIFT;
               end
            end
            S_SHIFT: begin
               div_q <= div_q + 2'h1;
               if (div_q == 2'(SCK_HALF_DIV - 1)) begin
                  sck_q <= 1'b1;
               end else if (div_q == 2'(2 * SCK_HALF_DIV - 1)) begin
                  sck_q <= 1'b0;
                  tx_q <= {tx_q[14:0], 1'b0};
                  // Read bit sampled at the end of the high half, as the clock falls, after sync delay
                  rx_q <= {rx_q[6:0], so_s};
                  bits_left_q <= bits_left_q - 8'h01;
                  if (bits_left_q == 8'h01) begin
                     state_q <= S_END;
                  end
               end
            end
            default: begin
               cs_n_q <= 1'b1;
               if (is_read_q) begin
                  status_q <= rx_q;
               end
               done_q <= 1'b1;
               state_q <= S_IDLE;
            end
         endcase
      end
   end
   assign LINK.sck = sck_q;
   assign LINK.cs_n = cs_n_q;
   assign LINK.si = tx_q[15];
   assign LINK.wp_n = WP_N_IN;
   assign READY_OUT = (state_q == S_IDLE);
   assign DONE_OUT = done_q;
   assign STATUS_OUT = status_q;
endmodule : flash_host
`default_nettype wire

/* logic/flash_link_if.sv */
// Serial link between host controller and flash command logic
`timescale 1ns/1ps
`default_nettype none
interface flash_link_if;
   logic sck;
   logic cs_n;
   logic si;
   logic so;
   logic so_oe_n;
   logic wp_n;
   modport device (input sck, input cs_n, input si, input wp_n, output so, output so_oe_n);
   modport host (output sck, output cs_n, output si, output wp_n, input so, input so_oe_n);
endinterface : flash_link_if
`default_nettype wire

/* logic/flash_sync3.sv */
// Three-stage synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module flash_sync3 #(parameter logic INIT = 1'b0) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic d_in,
   output logic q_out
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic q_q;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         q_q <= INIT;
      end else begin
         s1_q <= d_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            q_q <= s3_q;
         end
      end
   end
   assign q_out = q_q;
endmodule : flash_sync3
`default_nettype wire

/* sim/flash_link_asserts.sv */
// Protocol checks on the serial link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module flash_link_asserts
   import flash_ctrl_pkg::*;
(
   input wire logic REF_CLK_IN,
   input wire logic RSTN_IN,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe_n,
   input wire logic wp_n
);
   // ----------------------------------------------------------------
   // Frame tracking
   // ----------------------------------------------------------------
   logic sck_q;
   logic [7:0] bits_q;
   logic [7:0] op_q;
   logic [3:0] high_q;
   wire sck_rise = sck && !sck_q;
   wire take_bit = !cs_n && sck_rise;
   always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         sck_q <= 1'b0;
         bits_q <= 8'h00;
         op_q <= 8'h00;
         high_q <= 4'h0;
      end else begin
         sck_q <= sck;
         bits_q <= cs_n ? 8'h00 : (take_bit ? bits_q + 8'h01 : bits_q);
         op_q <= (take_bit && bits_q < 8'h08) ? {op_q[6:0], si} : op_q;
         high_q <= !cs_n ? 4'h0 : ((high_q != 4'hf) ? high_q + 4'h1 : high_q);
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   sck_idle_low_a: assert property (cs_n |-> !sck) // clock idle
      else $error("serial clock moves while deselected");
   sck_starts_low_a: assert property ($fell(cs_n) |-> !sck) // clock start
      else $error("serial clock high when select falls");
   si_steady_high_a: assert property (sck && sck_q |-> $stable(si)) // input sampling
      else $error("serial input changes while clock high");
   frame_whole_bytes_a: assert property ($rose(cs_n) |-> bits_q[2:0] == 3'h0 && bits_q != 8'h00) // byte frames
      else $error("frame does not end on a byte boundary");
   select_gap_a: assert property ($rose(cs_n) |-> cs_n [*8]) // select spacing
      else $error("select high time too short");
   so_release_a: assert property ($rose(cs_n) |-> ##[0:8] so_oe_n) // output stops
      else $error("serial output still driven after select rise");
   so_idle_off_a: assert property (high_q >= 4'h9 |-> so_oe_n) // output idle
      else $error("serial output driven while deselected");
   so_read_only_a: assert property ($fell(so_oe_n) |=> op_q == STATUS_READ_OP && bits_q == 8'h08) // read output
      else $error("serial output driven outside a status read");
   wp_steady_frame_a: assert property (!cs_n && !$past(cs_n) |-> $stable(wp_n)) // pin steady
      else $error("protect pin changes inside a frame");
endmodule : flash_link_asserts
`default_nettype wire

/* sim/serial_flash_erase_status_ctrl_tb_top.sv */
// Bench joining host and device ends over the serial link
`timescale 1ns/1ps
`default_nettype none
module serial_flash_erase_status_ctrl_tb_top
   import flash_ctrl_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rstn;
   logic req = 1'b0;
   logic [7:0] opcode = 8'h00;
   logic [7:0] data = 8'h00;
   logic has_data = 1'b0;
   logic [3:0] read_bytes = 4'h0;
   logic wp_n_pin = 1'b1;
   logic ready;
   logic done;
   logic busy;
   logic erased;
   logic [7:0] status;
   int mismatches = 0;
   int checked = 0;
   always #20 ref_clk = ~ref_clk;
   flash_link_if link();
   // Short erase keeps the run brief; long enough to poke at it while busy
   flash_device #(.ERASE_CYCLES(600)) u_flash_device (.REF_CLK_IN(ref_clk), .RSTN_IN(rstn), .LINK(link.device),
      .BUSY_OUT(busy), .ARRAY_ERASED_OUT(erased));
   flash_host u_flash_host (.REF_CLK_IN(ref_clk), .RSTN_IN(rstn), .LINK(link.host), .REQ_IN(req),
      .OPCODE_IN(opcode), .DATA_IN(data), .HAS_DATA_IN(has_data), .READ_BYTES_IN(read_bytes),
      .WP_N_IN(wp_n_pin), .READY_OUT(ready), .DONE_OUT(done), .STATUS_OUT(status));
   flash_link_asserts u_flash_link_asserts (.REF_CLK_IN(ref_clk), .RSTN_IN(rstn), .sck(link.sck),
      .cs_n(link.cs_n), .si(link.si), .so(link.so), .so_oe_n(link.so_oe_n), .wp_n(link.wp_n));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check8
   task automatic send(input logic [7:0] op, input logic [7:0] dat, input logic hd, input logic [3:0] nb);
      int n;
      @(posedge ref_clk);
      req <= 1'b1;
      opcode <= op;
      data <= dat;
      has_data <= hd;
      read_bytes <= nb;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ready !== 1'b1 && n < 100);
      req <= 1'b0;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (done !== 1'b1 && n < 2000);
      if (done !== 1'b1) mismatches++;
      // Keeps select high well past the minimum gap and the device's syncs
      repeat (12) @(posedge ref_clk);
   endtask : send
   task automatic rd(input logic [7:0] exp);
      send(STATUS_READ_OP, 8'h00, 1'b0, 4'h1); // one-byte read
      check8(status, exp); // status compare
   endtask : rd
   task automatic wait_idle();
      int n;
      n = 0;
      // poll busy before the next command
      while (busy !== 1'b0 && n < 2000) begin
         @(posedge ref_clk);
         n++;
      end
      check8({7'h00, busy}, 8'h00); // busy cleared
   endtask : wait_idle
   task automatic status_write_cmd(input logic wp, input logic [7:0] val);
      @(posedge ref_clk);
      wp_n_pin <= wp;
      send(STATUS_WRITE_ARM_OP, 8'h00, 1'b0, 4'h0); // arm
      send(STATUS_WRITE_OP, val, 1'b1, 4'h0); // framed write
      wait_idle(); // write completes
   endtask : status_write_cmd
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      // Non-blocking at time zero, so every reset process sees the falling edge
      rstn <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(8'h00); // idle status
      $display("test reset done");
      send(WHOLE_ERASE_OP_A, 8'h00, 1'b0, 4'h0); // erase with latch clear
      check8({6'h00, erased, busy}, 8'h00); // erase without latch
      send(WRITE_LATCH_SET_OP, 8'h00, 1'b0, 4'h0); // set latch
      rd(8'h02); // latch set
      send(WRITE_LATCH_CLEAR_OP, 8'h00, 1'b0, 4'h0); // clear latch
      rd(8'h00); // latch clear
      $display("test latch done");
      send(STATUS_WRITE_ARM_OP, 8'h00, 1'b0, 4'h0); // arm
      send(WRITE_LATCH_CLEAR_OP, 8'h00, 1'b0, 4'h0); // other command between
      send(STATUS_WRITE_OP, 8'h1c, 1'b1, 4'h0); // write after lost arming
      rd(8'h00); // arming dropped
      status_write_cmd(1'b1, 8'h9f); // lock and levels in one write
      rd(8'h9c); // lock and levels together
      status_write_cmd(1'b0, 8'h00); // pin low while locked
      rd(8'h9c); // locked write ignored
      status_write_cmd(1'b1, 8'h00); // pin high unlocks
      rd(8'h00); // unlocked by pin
      status_write_cmd(1'b0, 8'h80); // lock up with pin low
      rd(8'h80); // lock rises with pin low
      status_write_cmd(1'b1, 8'h04); // levels with pin high
      rd(8'h04); // levels writable
      $display("test status write done");
      send(WRITE_LATCH_SET_OP, 8'h00, 1'b0, 4'h0); // latch for erase
      send(WHOLE_ERASE_OP_A, 8'h00, 1'b0, 4'h0); // erase while protected
      check8({6'h00, erased, busy}, 8'h00); // protected erase dropped
      status_write_cmd(1'b1, 8'h00); // clear protection
      rd(8'h00); // latch cleared after write
      $display("test protect done");
      for (int i = 0; i < 2; i++) begin
         send(WRITE_LATCH_SET_OP, 8'h00, 1'b0, 4'h0); // latch before erase
         send((i == 0) ? WHOLE_ERASE_OP_A : WHOLE_ERASE_OP_B, 8'h00, 1'b0, 4'h0); // either opcode
         check8({7'h00, busy}, 8'h01); // erase running
         send(STATUS_READ_OP, 8'h00, 1'b0, 4'h2); // two-byte read while busy
         check8(status, 8'h03); // busy read repeated
         send(STATUS_WRITE_ARM_OP, 8'h00, 1'b0, 4'h0); // arm while busy
         send(STATUS_WRITE_OP, 8'h1c, 1'b1, 4'h0); // write while busy
         wait_idle(); // erase completes
         rd(8'h00); // busy ignored write
         check8({7'h00, erased}, 8'h01); // array erased
      end
      $display("test erase done");
      end_of_test();
   end
   // Expected run is near 4800 cycles; this leaves ample margin
   initial begin
      repeat (30000) @(posedge ref_clk);
      mismatches++;
      end_of_test();
   end
endmodule : serial_flash_erase_status_ctrl_tb_top
`default_nettype wire
